/* File: hw/tse_pkg.sv */
package tse_pkg;

   // build-time limits per expression and per analyzer core
   localparam int TSE_MAX_STAGES = 16;
   localparam int TSE_MAX_EXPR = 16;
   localparam int TSE_MAX_COUNT = 65536;
   localparam int TSE_NUM_UNITS = 16;
   localparam int TSE_NUM_TERMS = 4;

   // values after reset
   localparam int TSE_RST_STAGE = 0;
   localparam int TSE_RST_COUNT = 0;

   // combining operator applied between a term and the running result
   typedef enum logic [1:0] {
      TSE_OP_AND = 2'h0,
      TSE_OP_OR = 2'h1,
      TSE_OP_XOR = 2'h2
   } tse_op_e;

   // gray along idle -> run -> hit
   typedef enum logic [1:0] {
      TSE_ST_IDLE = 2'h0,
      TSE_ST_RUN = 2'h1,
      TSE_ST_HIT = 2'h3
   } tse_state_e;

endpackage : tse_pkg

/* File: hw/tse_stage_cond.sv */
`timescale 1ns/1ps
`default_nettype none

module tse_stage_cond #(
   parameter int NUM_UNITS = tse_pkg::TSE_NUM_UNITS,
   parameter int NUM_TERMS = tse_pkg::TSE_NUM_TERMS,
   parameter int SEL_W = (NUM_UNITS > 1) ? $clog2(NUM_UNITS) : 1
) (
   // trigger unit results
   input wire logic [NUM_UNITS-1:0] trig_unit_match,
   // stage condition
   input wire logic always_true,
   input wire logic [NUM_TERMS*SEL_W-1:0] term_sel,
   input wire logic [NUM_TERMS-1:0] term_neg,
   input wire logic [2*NUM_TERMS-1:0] term_op,
   input wire logic [NUM_TERMS-1:0] term_en,
   // result
   output logic cond
);

   logic acc;
   logic any;
   logic t;
   logic [SEL_W-1:0] sel;

   always_comb begin
      acc = 1'b0;
      any = 1'b0;
      t = 1'b0;
      sel = '0;
      for (int i = 0; i < NUM_TERMS; i++) begin
         if (term_en[i]) begin
            sel = term_sel[i*SEL_W +: SEL_W];
            // negation is applied to the unit before any combining
            t = ((int'(sel) < NUM_UNITS) ? trig_unit_match[sel] : 1'b0) ^ term_neg[i]; // [R12]
            if (!any) begin
               acc = t;
            end else begin
               // strict left-to-right fold, all operators equal rank
               case (tse_pkg::tse_op_e'(term_op[2*i +: 2])) // [R11]
                  tse_pkg::TSE_OP_AND: acc = acc & t;
                  tse_pkg::TSE_OP_OR: acc = acc | t;
                  tse_pkg::TSE_OP_XOR: acc = acc ^ t; // [R12]
                  default: acc = acc;
               endcase
            end
            any = 1'b1;
         end
      end
      cond = always_true | (any & acc); // [R8]
   end

endmodule : tse_stage_cond

`default_nettype wire

/* File: hw/tse_engine.sv */
// Contract
// [R1] Consecutive-count stage needs its condition on back-to-back clocks to complete.
// [R2] Stage completes only when its counter reaches the programmed occurrence count.
// [R3] Counter ceiling is a build parameter; programmed counts are clamped to it.
// [R4] After THEN, next stage is looked for from the following clock on, indefinitely.
// [R5] After NEXT, next stage must match the very next clock, else restart.
// [R6] Plain count accumulates matches whether adjacent or separated.
// [R7] A gap inside a consecutive count fails and restarts from stage one.
// [R8] Always-true stage with count N is a delay of N clocks.
// [R9] Each stage has exactly one counter over its whole condition.
// [R10] Host must not program a plain count on a stage after NEXT.
// [R11] Stages are delimited by links; terms fold strictly left to right.
// [R12] Negation binds to its unit first; XOR ranks with AND and OR.
// [R13] Single-stage expression triggers whenever its unit condition matches; code triggers once per arming, then idles until rearmed.
// [R14] Stages are evaluated strictly in order; no condition spans two stages.
// [R15] An expression with more stages than built for is rejected.
// [R16] Each instance has its own build-time maximum stage count.
// [R17] Up to sixteen stages per expression are supported.
// [R18] Up to sixteen expressions per core, each enabled at run time.
// [R19] Stage counters hold counts up to 65,536 at most.
// [R20] State advances on the sample clock; arming restarts at stage one.
// [R21] On final completion trigger pulses one clock, then idle until rearmed.
`timescale 1ns/1ps
`default_nettype none

module tse_engine #(
   parameter int NUM_UNITS = tse_pkg::TSE_NUM_UNITS,
   parameter int NUM_TERMS = tse_pkg::TSE_NUM_TERMS,
   parameter int MAX_STAGES = tse_pkg::TSE_MAX_STAGES,
   parameter int MAX_COUNT = tse_pkg::TSE_MAX_COUNT,
   parameter int SEL_W = (NUM_UNITS > 1) ? $clog2(NUM_UNITS) : 1,
   parameter int STG_W = (MAX_STAGES > 1) ? $clog2(MAX_STAGES) : 1,
   parameter int NUM_W = $clog2(MAX_STAGES + 1),
   parameter int CNT_W = $clog2(MAX_COUNT + 1)
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // trigger unit results
   input wire logic [NUM_UNITS-1:0] trig_unit_match,
   // control
   input wire logic arm,
   input wire logic expr_enable,
   // expression program
   input wire logic [NUM_W-1:0] cfg_num_stages,
   input wire logic [MAX_STAGES-1:0] cfg_link_next,
   input wire logic [MAX_STAGES-1:0] cfg_consec,
   input wire logic [MAX_STAGES-1:0] cfg_always,
   input wire logic [MAX_STAGES*CNT_W-1:0] cfg_count,
   input wire logic [MAX_STAGES*NUM_TERMS*SEL_W-1:0] cfg_term_sel,
   input wire logic [MAX_STAGES*NUM_TERMS-1:0] cfg_term_neg,
   input wire logic [MAX_STAGES*NUM_TERMS*2-1:0] cfg_term_op,
   input wire logic [MAX_STAGES*NUM_TERMS-1:0] cfg_term_en,
   // status
   output logic trig,
   output logic running,
   output logic cfg_err,
   output logic [STG_W-1:0] cur_stage
);

   localparam logic [CNT_W-1:0] MAX_CNT_V = CNT_W'(MAX_COUNT);
   localparam logic [CNT_W-1:0] ONE_CNT = CNT_W'(1);

   typedef struct packed {
      tse_pkg::tse_state_e st;
      logic [STG_W-1:0] stg;
      logic [CNT_W-1:0] cnt;
      logic [NUM_W-1:0] num;
      logic entered;
      logic trig;
      logic running;
      logic err;
   } tse_eng_s;

   tse_eng_s q;
   tse_eng_s d;

   logic cond;
   logic cur_next;
   logic cur_consec;
   logic cur_always;
   logic [CNT_W-1:0] cur_raw;
   logic [CNT_W-1:0] eff;
   logic [CNT_W:0] cnt_inc;
   logic [NUM_TERMS*SEL_W-1:0] cur_sel;
   logic [NUM_TERMS-1:0] cur_neg;
   logic [2*NUM_TERMS-1:0] cur_op;
   logic [NUM_TERMS-1:0] cur_en;
   logic is_last;
   logic done;
   logic bad;

   // only the active stage's program is decoded; one shared evaluator
   always_comb begin
      cur_next = cfg_link_next[q.stg];
      cur_consec = cfg_consec[q.stg];
      cur_always = cfg_always[q.stg];
      cur_raw = cfg_count[int'(q.stg)*CNT_W +: CNT_W];
      cur_sel = cfg_term_sel[int'(q.stg)*NUM_TERMS*SEL_W +: NUM_TERMS*SEL_W];
      cur_neg = cfg_term_neg[int'(q.stg)*NUM_TERMS +: NUM_TERMS];
      cur_op = cfg_term_op[int'(q.stg)*NUM_TERMS*2 +: NUM_TERMS*2];
      cur_en = cfg_term_en[int'(q.stg)*NUM_TERMS +: NUM_TERMS];
      // zero means one; anything above the built ceiling is clamped
      if (cur_raw == '0) begin
         eff = ONE_CNT;
      end else if (cur_raw > MAX_CNT_V) begin // [R3] [R19]
         eff = MAX_CNT_V;
      end else begin
         eff = cur_raw;
      end
   end

   tse_stage_cond #(
      .NUM_UNITS(NUM_UNITS),
      .NUM_TERMS(NUM_TERMS),
      .SEL_W(SEL_W)
   ) u_cond (
      .trig_unit_match(trig_unit_match),
      .always_true(cur_always),
      .term_sel(cur_sel),
      .term_neg(cur_neg),
      .term_op(cur_op),
      .term_en(cur_en),
      .cond(cond)
   );

   // program check at arm time: stage budget and count after NEXT
   always_comb begin
      bad = (cfg_num_stages == '0) || (int'(cfg_num_stages) > MAX_STAGES); // [R15] [R16]
      for (int i = 1; i < MAX_STAGES; i++) begin
         if (i < int'(cfg_num_stages) && cfg_link_next[i] && !cfg_consec[i]
             && cfg_count[i*CNT_W +: CNT_W] > ONE_CNT) begin
            bad = 1'b1; // [R10]
         end
      end
   end

   always_comb begin
      cnt_inc = {1'b0, q.cnt} + {{CNT_W{1'b0}}, 1'b1};
      is_last = ({{(32-STG_W){1'b0}}, q.stg} + 32'h1) == {{(32-NUM_W){1'b0}}, q.num};
      done = cnt_inc >= {1'b0, eff}; // [R2] [R9]
   end

   always_comb begin
      d = q;
      d.trig = 1'b0;
      if (arm && expr_enable) begin
         // arming always restarts from the first stage
         d.err = bad; // [R15]
         d.stg = STG_W'(tse_pkg::TSE_RST_STAGE); // [R20]
         d.cnt = CNT_W'(tse_pkg::TSE_RST_COUNT);
         d.entered = 1'b0;
         d.num = cfg_num_stages;
         d.st = bad ? tse_pkg::TSE_ST_IDLE : tse_pkg::TSE_ST_RUN;
      end else begin
         case (q.st)
            tse_pkg::TSE_ST_RUN: begin
               d.entered = 1'b0;
               if (!expr_enable) begin
                  d.st = tse_pkg::TSE_ST_IDLE; // [R18]
               end else if ((q.entered && cur_next && !cond) // [R5]
                            || (cur_consec && q.cnt != '0 && !cond)) begin // [R1] [R7]
                  d.stg = STG_W'(tse_pkg::TSE_RST_STAGE);
                  d.cnt = CNT_W'(tse_pkg::TSE_RST_COUNT);
               end else if (cond) begin
                  if (done && is_last) begin
                     d.st = tse_pkg::TSE_ST_HIT; // [R13] [R21]
                     d.trig = 1'b1;
                  end else if (done) begin
                     // next stage is first examined on the following clock
                     d.stg = q.stg + STG_W'(1); // [R4] [R14] [R17]
                     d.cnt = CNT_W'(tse_pkg::TSE_RST_COUNT);
                     d.entered = 1'b1;
                  end else begin
                     d.cnt = cnt_inc[CNT_W-1:0]; // [R6] [R8]
                  end
               end
            end
            tse_pkg::TSE_ST_HIT: begin
               d.st = tse_pkg::TSE_ST_IDLE; // [R21]
            end
            tse_pkg::TSE_ST_IDLE: begin
               d.st = tse_pkg::TSE_ST_IDLE;
            end
            default: begin
               d.st = tse_pkg::TSE_ST_IDLE;
            end
         endcase
      end
      d.running = (d.st == tse_pkg::TSE_ST_RUN);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '{st: tse_pkg::TSE_ST_IDLE, stg: '0, cnt: '0, num: '0,
                entered: 1'b0, trig: 1'b0, running: 1'b0, err: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign trig = q.trig;
   assign running = q.running;
   assign cfg_err = q.err;
   assign cur_stage = q.stg;

   // a rearm in the pulse cycle is legal and goes straight back to run, or to idle with cfg_err when the program is rejected
   property p_trig_single;
      @(posedge clk) disable iff (rst)
      (q.trig && !(arm && expr_enable)) |=> !q.trig && q.st == tse_pkg::TSE_ST_IDLE;
   endproperty
   a_trig_single: assert property (p_trig_single) else $error("trigger not single"); // [R21]

   property p_arm_start;
      @(posedge clk) disable iff (rst)
      (arm && expr_enable && !bad) |=> q.running && q.stg == '0 && q.cnt == '0;
   endproperty
   a_arm_start: assert property (p_arm_start) else $error("arm did not restart"); // [R20]

   property p_reject;
      @(posedge clk) disable iff (rst)
      (arm && expr_enable && bad) |=> q.err && !q.running;
   endproperty
   a_reject: assert property (p_reject) else $error("bad program ran"); // [R15]

   property p_next_fail;
      @(posedge clk) disable iff (rst)
      (q.running && !arm && expr_enable && q.entered && cur_next && !cond)
         |=> q.stg == '0 && q.cnt == '0;
   endproperty
   a_next_fail: assert property (p_next_fail) else $error("next link miss kept"); // [R5]

   property p_consec_fail;
      @(posedge clk) disable iff (rst)
      (q.running && !arm && expr_enable && cur_consec && q.cnt != '0 && !cond)
         |=> q.stg == '0 && q.cnt == '0;
   endproperty
   a_consec_fail: assert property (p_consec_fail) else $error("gap kept count"); // [R7]

   property p_count_up;
      @(posedge clk) disable iff (rst)
      (q.running && !arm && expr_enable && cond && !done && !(q.entered && cur_next))
         |=> q.cnt == $past(q.cnt) + ONE_CNT && q.stg == $past(q.stg);
   endproperty
   a_count_up: assert property (p_count_up) else $error("count not tallied"); // [R6]

   property p_advance;
      @(posedge clk) disable iff (rst)
      (q.running && !arm && expr_enable && cond && done && !is_last)
         |=> q.stg == $past(q.stg) + STG_W'(1) && q.cnt == '0 && q.entered;
   endproperty
   a_advance: assert property (p_advance) else $error("stage not advanced"); // [R14]

   property p_hold;
      @(posedge clk) disable iff (rst)
      (q.running && !arm && expr_enable && !cond && !q.entered && q.cnt == '0)
         |=> q.stg == $past(q.stg) && q.running;
   endproperty
   a_hold: assert property (p_hold) else $error("then wait abandoned"); // [R4]

   property p_ceiling;
      @(posedge clk) disable iff (rst)
      q.cnt < MAX_CNT_V;
   endproperty
   a_ceiling: assert property (p_ceiling) else $error("counter above ceiling"); // [R3]

   property p_final;
      @(posedge clk) disable iff (rst)
      (q.running && !arm && expr_enable && cond && done && is_last) |=> q.trig;
   endproperty
   a_final: assert property (p_final) else $error("final stage no trigger"); // [R2]

endmodule : tse_engine

`default_nettype wire

/* File: verification/tse_tu_model.sv */
`timescale 1ns/1ps
`default_nettype none

module tse_tu_model (
   // watched user signals
   input wire logic [15:0] user_bus,
   // compare value per unit
   input wire logic [15:0] ref_val,
   // unit results
   output logic [15:0] trig_unit_match
);
   // one-bit equality per unit; value and operator stay out of the engine
   assign trig_unit_match = ~(user_bus ^ ref_val);
endmodule : tse_tu_model

`default_nettype wire

/* File: verification/trigger_sequence_engine_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module trigger_sequence_engine_tb;
   // small build limits keep runs short
   localparam int MS = 4;
   localparam int MC = 8;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic arm = 1'b0;
   logic en = 1'b1;
   logic [15:0] ubus = 16'h0000;
   logic [15:0] tu;
   logic [2:0] n_st = 3'h0;
   logic [MS-1:0] lnk = '0, cs = '0, al = '0;
   logic [MS*4-1:0] cnt = '0, neg = '0, ten = '0;
   logic [MS*16-1:0] sel = '0;
   logic [MS*8-1:0] op = '0;
   logic trig, running, cfg_err;
   logic [1:0] cur;
   int err_total = 0;
   int n_tests = 0;

   tse_tu_model tu_u (.user_bus(ubus), .ref_val(16'hFFFF), .trig_unit_match(tu));

   tse_engine #(.MAX_STAGES(MS), .MAX_COUNT(MC)) dut_u (
      .clk(clk), .rst(rst), .trig_unit_match(tu), .arm(arm), .expr_enable(en),
      .cfg_num_stages(n_st), .cfg_link_next(lnk), .cfg_consec(cs), .cfg_always(al),
      .cfg_count(cnt), .cfg_term_sel(sel), .cfg_term_neg(neg), .cfg_term_op(op),
      .cfg_term_en(ten), .trig(trig), .running(running), .cfg_err(cfg_err),
      .cur_stage(cur));

   initial forever #2.5 clk = ~clk;

   task chk(input logic [3:0] seen, input logic [3:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task report_and_stop;
      if (err_total == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop

   task clr;
      lnk = '0; cs = '0; al = '0; cnt = '0; sel = '0; neg = '0; op = '0; ten = '0;
   endtask : clr

   task stg(input int s, input logic nx, input logic c, input logic a, input logic [3:0] n);
      lnk[s] = nx; cs[s] = c; al[s] = a; cnt[s*4+:4] = n;
   endtask : stg

   task trm(input int s, input int t, input logic [3:0] u, input logic ng, input logic [1:0] o);
      sel[(s*4+t)*4+:4] = u; neg[s*4+t] = ng; op[(s*4+t)*2+:2] = o; ten[s*4+t] = 1'b1;
   endtask : trm

   // arm pulse, then the stage evaluation starts at the following edge
   task go(input logic [2:0] n, input logic e);
      n_st = n;
      @(negedge clk);
      arm = 1'b1;
      @(negedge clk);
      arm = 1'b0;
      chk(running, !e);
      chk(cfg_err, e);
   endtask : go

   // trig is expected only after the edge that samples p[hit]
   task seq(input logic [15:0] p[$], input int hit);
      for (int i = 0; i <= p.size(); i++) begin
         if (i > 0) begin
            @(negedge clk);
            chk(trig, i - 1 == hit);
         end
         if (i < p.size()) ubus = p[i];
      end
      ubus = 16'h0000;
   endtask : seq

   task s_basic;
      clr;
      stg(0, 0, 0, 0, 4'h1);
      trm(0, 0, 4'h1, 1'b0, 2'h0);
      go(3'h1, 1'b0);
      seq('{16'h0000, 16'h0000, 16'h0002, 16'h0000, 16'h0002, 16'h0000}, 2);
      chk(running, 1'b0);
      stg(1, 0, 0, 0, 4'h1);
      trm(1, 0, 4'h2, 1'b0, 2'h0);
      go(3'h2, 1'b0);
      seq('{16'h0004, 16'h0006, 16'h0000, 16'h0000, 16'h0004, 16'h0000}, 4);
      go(3'h2, 1'b0);
      seq('{16'h0002}, -1);
      chk(cur, 4'h1);
      go(3'h2, 1'b0);
      chk(cur, 4'h0);
      lnk[1] = 1'b1;
      go(3'h2, 1'b0);
      seq('{16'h0002, 16'h0000, 16'h0004, 16'h0002, 16'h0004, 16'h0000}, 4);
   endtask : s_basic

   task s_count;
      lnk[1] = 1'b0;
      stg(0, 0, 0, 0, 4'h3);
      go(3'h2, 1'b0);
      seq('{16'h0002, 16'h0000, 16'h0002, 16'h0004, 16'h0002, 16'h0004, 16'h0000}, 5);
      cs[0] = 1'b1;
      go(3'h2, 1'b0);
      seq('{16'h0002, 16'h0002, 16'h0000, 16'h0002, 16'h0004, 16'h0002, 16'h0002,
            16'h0002, 16'h0004, 16'h0000}, 8);
   endtask : s_count

   task s_delay;
      logic [15:0] p[$];
      cnt = '0;
      cs[0] = 1'b0;
      cnt[3:0] = 4'h1;
      // second pass asks for more than the built ceiling
      for (int j = 0; j < 2; j++) begin
         stg(1, 0, 0, 1, (j == 0) ? 4'h3 : 4'hF);
         p.delete();
         p.push_back(16'h0002);
         repeat (10) p.push_back(16'h0000);
         go(3'h2, 1'b0);
         seq(p, (j == 0) ? 3 : MC);
      end
   endtask : s_delay

   task s_logic;
      logic x;
      clr;
      stg(0, 0, 0, 0, 4'h1);
      trm(0, 0, 4'h1, 1'b1, tse_pkg::TSE_OP_OR);
      trm(0, 1, 4'h2, 1'b0, tse_pkg::TSE_OP_AND);
      // third pass: operator code 3 keeps the running result
      for (int o = 0; o < 3; o++) begin
         trm(0, 2, 4'h3, 1'b0, (o == 0) ? 2'h1 : ((o == 1) ? 2'h2 : 2'h3));
         for (int v = 0; v < 8; v++) begin
            case (o)
               0: x = (!v[0] && v[1]) || v[2];
               1: x = (!v[0] && v[1]) ^ v[2];
               default: x = !v[0] && v[1];
            endcase
            go(3'h1, 1'b0);
            seq('{16'(v << 1), 16'h0000}, x ? 0 : -1);
         end
      end
   endtask : s_logic

   task s_refuse;
      // stage one back to a lone unit so only the link under test matters
      clr;
      stg(0, 0, 0, 0, 4'h1);
      trm(0, 0, 4'h1, 1'b0, 2'h0);
      go(3'h5, 1'b1);
      go(3'h0, 1'b1);
      stg(1, 1, 0, 0, 4'h2);
      trm(1, 0, 4'h2, 1'b0, 2'h0);
      go(3'h2, 1'b1);
      seq('{16'h0002, 16'h0004, 16'h0004, 16'h0000}, -1);
      cs[1] = 1'b1;
      go(3'h2, 1'b0);
      seq('{16'h0002, 16'h0004, 16'h0004, 16'h0000}, 2);
      go(3'h2, 1'b0);
      en = 1'b0;
      @(negedge clk);
      chk(running, 1'b0);
      arm = 1'b1;
      @(negedge clk);
      arm = 1'b0;
      chk(running, 1'b0);
      en = 1'b1;
   endtask : s_refuse

   initial begin
      repeat (3) @(negedge clk);
      chk({trig, running, cfg_err, 1'b0}, 4'h0);
      chk(cur, 4'h0);
      rst = 1'b0;
      s_basic;
      s_count;
      s_delay;
      s_logic;
      s_refuse;
      report_and_stop;
   end

   // whole run is well under 1000 cycles
   initial begin
      #20000;
      err_total++;
      report_and_stop;
   end
endmodule : trigger_sequence_engine_tb

`default_nettype wire
